// File: src/psp_pkg.sv
// package for the parallel slave port: register offsets, bit positions, resets
// assumes a 32-bit apb register bus with byte addresses four times the index
package psp_pkg;
  // register indexes and byte addresses (index times four)
  localparam logic [7:0]  IDX_DATA    = 8'h08;
  localparam logic [7:0]  IDX_STROBE  = 8'h09;
  localparam logic [7:0]  IDX_FLAGS   = 8'h0C;
  localparam logic [7:0]  IDX_CTRL    = 8'h89;
  localparam logic [7:0]  IDX_ENABLES = 8'h8C;
  localparam logic [11:0] ADDR_DATA    = {2'h0, IDX_DATA, 2'h0};
  localparam logic [11:0] ADDR_STROBE  = {2'h0, IDX_STROBE, 2'h0};
  localparam logic [11:0] ADDR_FLAGS   = {2'h0, IDX_FLAGS, 2'h0};
  localparam logic [11:0] ADDR_CTRL    = {2'h0, IDX_CTRL, 2'h0};
  localparam logic [11:0] ADDR_ENABLES = {2'h0, IDX_ENABLES, 2'h0};
  // control/status bit positions
  localparam int BIT_IN_FULL  = 7;
  localparam int BIT_OUT_FULL = 6;
  localparam int BIT_OVERFLOW = 5;
  localparam int BIT_MODE     = 4;
  localparam int BIT_IRQ      = 7;
  // reset values
  localparam logic [2:0] RST_PIN_DIR = 3'h7;
  localparam logic [7:0] RST_BYTE    = 8'h00;
  localparam logic [7:0] RST_DATA_DIR = 8'hFF;
  // synchroniser depth
  localparam int SYNC_STAGES = 2;
  // external access state
  typedef enum logic [1:0] {
    EXT_IDLE  = 2'b00,
    EXT_READ  = 2'b01,
    EXT_WRITE = 2'b10
  } ext_state_e;
endpackage

// File: src/parallel_slave_port.sv
// parallel slave port: 8-bit latches toward an external processor, apb registers
// assumes strobe pins asynchronous to CORE_CLK; apb master synchronous to it
// Functional notes
// - mode bit 4 enables slave port
// - external strobes asynchronous, synchronised inside
// - strobe pins act as read, write, select
// - two latches share one data address
// - data direction register ignored in slave mode
// - input full set on write, cleared by read
// - output full set by cpu write
// - second write sets overflow, keeps first byte
// - full flags clear outside mode; overflow stays set
// - completed access sets sticky irq flag
// - irq enable gates the interrupt request
// - write commits at cycle end, read samples start
// - read plus select drives output latch
// - write plus select captures data pins
// - select high ignores both strobes
`timescale 1ns/1ps
module parallel_slave_port
  import psp_pkg::*;
(
  // clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        SYS_RST,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // external data bus pins (oe low drives)
  input  wire logic [7:0]  DATA_IN,
  output logic      [7:0]  DATA_OUT,
  output logic      [7:0]  DATA_OE_N,
  // external strobe pins, active low
  input  wire logic        READ_STROBE_N_PIN,
  input  wire logic        WRITE_STROBE_N_PIN,
  input  wire logic        CHIP_SELECT_N_PIN,
  // general-purpose direction for data port outside slave mode
  output logic      [7:0]  DATA_PORT_DIRECTION,
  // interrupt
  output logic             IRQ
);

  // synchroniser chains for the three strobes
  logic [SYNC_STAGES-1:0] rd_sync_q, rd_sync_d;
  logic [SYNC_STAGES-1:0] wr_sync_q, wr_sync_d;
  logic [SYNC_STAGES-1:0] cs_sync_q, cs_sync_d;
  // synchronised levels, active high
  logic rd_act, wr_act, cs_act;

  // block state; the synchronous reset clears every register below except the direction registers, which it sets to all ones
  ext_state_e  ext_q, ext_d;             // external access in progress
  logic [7:0]  out_latch_q, out_latch_d; // cpu to external
  logic [7:0]  in_latch_q, in_latch_d;   // external to cpu
  logic [7:0]  wr_data_q, wr_data_d;     // data held while write strobe low
  // control bits written by software
  logic        mode_q, mode_d;           // slave port enable
  logic [2:0]  pin_dir_q, pin_dir_d;     // strobe pin direction bits
  logic [7:0]  dir_q, dir_d;             // data port direction
  // status flags; hardware sets win over software clears
  logic        in_full_q, in_full_d;     // byte waits for the cpu
  logic        out_full_q, out_full_d;   // byte waits for the external side
  logic        ovf_q, ovf_d;             // second write while still full
  logic        irq_flag_q, irq_flag_d;   // sticky event flag
  logic        irq_en_q, irq_en_d;       // event flag may raise irq
  // bus side
  logic [31:0] prdata_q, prdata_d;       // read data, loaded in setup phase
  logic        rd_drive_q, rd_drive_d;   // drive pins during external read

  // apb decode
  logic apb_acc, apb_wr, apb_rd, addr_ok;
  // one-cycle pulses at the end of an external access
  logic rd_done, wr_done;

  // synchroniser next values: first stage only feeds the second
  // limitation: a strobe level shorter than one clock may be missed, so
  // the far side must hold each level for at least three clocks
  always_comb begin
    rd_sync_d = {rd_sync_q[0], ~READ_STROBE_N_PIN};
    wr_sync_d = {wr_sync_q[0], ~WRITE_STROBE_N_PIN};
    cs_sync_d = {cs_sync_q[0], ~CHIP_SELECT_N_PIN};
  end

  // synchroniser flops
  // reset clears the chains, so the strobes read as idle at once
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      rd_sync_q <= '0;
      wr_sync_q <= '0;
      cs_sync_q <= '0;
    end else begin
      rd_sync_q <= rd_sync_d;
      wr_sync_q <= wr_sync_d;
      cs_sync_q <= cs_sync_d;
    end
  end

  // only the last stage is read by logic
  // by then a metastable first stage has had a full clock to settle
  always_comb begin
    rd_act = rd_sync_q[SYNC_STAGES-1];
    wr_act = wr_sync_q[SYNC_STAGES-1];
    cs_act = cs_sync_q[SYNC_STAGES-1];
  end

  // apb decode; zero-wait slave, so each access phase lasts one cycle
  // and a master never waits on this block
  always_comb begin
    apb_acc = PSEL & PENABLE;
    apb_wr  = apb_acc & PWRITE;
    apb_rd  = apb_acc & ~PWRITE;
    addr_ok = (PADDR == ADDR_DATA) || (PADDR == ADDR_STROBE) ||
              (PADDR == ADDR_FLAGS) || (PADDR == ADDR_CTRL) ||
              (PADDR == ADDR_ENABLES);
    // no wait states: every register answers at once
    PREADY  = 1'b1;
  end

  // external access tracker and latch/flag next values
  // every value holds unless an event or a clear below moves it
  always_comb begin
    ext_d       = ext_q;
    out_latch_d = out_latch_q;
    in_latch_d  = in_latch_q;
    wr_data_d   = wr_data_q;
    mode_d      = mode_q;
    pin_dir_d   = pin_dir_q;
    dir_d       = dir_q;
    in_full_d   = in_full_q;
    out_full_d  = out_full_q;
    ovf_d       = ovf_q;
    irq_flag_d  = irq_flag_q;
    irq_en_d    = irq_en_q;
    rd_done     = 1'b0;
    wr_done     = 1'b0;
    // access tracking; only in slave mode, select gates strobes
    case (ext_q)
      EXT_IDLE: begin
        // a read wins when both strobes are seen low together
        if (mode_q && cs_act && rd_act) begin
          ext_d = EXT_READ;
        end else if (mode_q && cs_act && wr_act) begin
          ext_d = EXT_WRITE;
        end
      end
      EXT_READ: begin
        // end of read when strobe or select released
        if (!(rd_act && cs_act) || !mode_q) begin
          ext_d   = EXT_IDLE;
          rd_done = mode_q;
        end
      end
      EXT_WRITE: begin
        // keep sampling pins while strobe low; commit at rising edge
        wr_data_d = DATA_IN;
        if (!(wr_act && cs_act) || !mode_q) begin
          ext_d   = EXT_IDLE;
          wr_done = mode_q;
          wr_data_d = wr_data_q;
        end
      end
      default: ext_d = EXT_IDLE;
    endcase
    // cpu writes commit at end of the access cycle
    if (apb_wr && PADDR == ADDR_DATA) begin
      out_latch_d = PWDATA[7:0];
      out_full_d  = 1'b1;
    end
    if (apb_wr && PADDR == ADDR_CTRL) begin
      mode_d    = PWDATA[BIT_MODE];
      // kept for software; the strobes are inputs to this block anyway
      pin_dir_d = PWDATA[2:0];
      // overflow is cleared by software writing zero
      if (!PWDATA[BIT_OVERFLOW]) begin
        ovf_d = 1'b0;
      end
    end
    if (apb_wr && PADDR == ADDR_STROBE) begin
      dir_d = PWDATA[7:0];
    end
    if (apb_wr && PADDR == ADDR_ENABLES) begin
      irq_en_d = PWDATA[BIT_IRQ];
    end
    // irq flag: write one to clear
    if (apb_wr && PADDR == ADDR_FLAGS && PWDATA[BIT_IRQ]) begin
      irq_flag_d = 1'b0;
    end
    // cpu read of input latch clears input full
    if (apb_rd && PADDR == ADDR_DATA) begin
      in_full_d = 1'b0;
    end
    // external events win over clears in the same cycle
    if (rd_done) begin
      // the output latch counts as read once the strobe is released
      out_full_d = 1'b0;
      irq_flag_d = 1'b1;
    end
    if (wr_done) begin
      irq_flag_d = 1'b1;
      if (in_full_q) begin
        ovf_d = 1'b1; // first byte kept
      end else begin
        in_latch_d = wr_data_q;
        in_full_d  = 1'b1;
      end
    end
    // outside slave mode full flags are forced clear
    if (!mode_q) begin
      in_full_d  = 1'b0;
      out_full_d = 1'b0;
    end
  end

  // apb read data, loaded in the setup phase so that a data read samples
  // the pins at the start of the transfer; held through the access phase
  always_comb begin
    prdata_d = prdata_q;
    if (PSEL && !PENABLE && !PWRITE) begin
      // setup phase of a read: capture the addressed register
      prdata_d = 32'h0;
      case (PADDR)
        ADDR_DATA: begin
          // slave mode reads the input latch, otherwise the pins
          prdata_d[7:0] = mode_q ? in_latch_q : DATA_IN;
        end
        ADDR_STROBE:  prdata_d[2:0] = {~CHIP_SELECT_N_PIN, ~WRITE_STROBE_N_PIN,
                                       ~READ_STROBE_N_PIN};
        ADDR_FLAGS:   prdata_d[BIT_IRQ] = irq_flag_q;
        ADDR_CTRL:    prdata_d[7:0] = {in_full_q, out_full_q, ovf_q, mode_q,
                                       1'b0, pin_dir_q};
        ADDR_ENABLES: prdata_d[BIT_IRQ] = irq_en_q;
        // unmapped addresses read as zero
        default:      prdata_d = 32'h0;
      endcase
    end else if (!apb_acc) begin
      // idle or write setup: no stale read data on the bus
      prdata_d = 32'h0;
    end
    // drive the pins only during a selected external read
    rd_drive_d = mode_q && (ext_d == EXT_READ);
  end

  // block state registers
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      ext_q       <= EXT_IDLE;
      out_latch_q <= RST_BYTE;
      in_latch_q  <= RST_BYTE;
      wr_data_q   <= RST_BYTE;
      mode_q      <= 1'b0;
      pin_dir_q   <= RST_PIN_DIR;
      dir_q       <= RST_DATA_DIR;
      in_full_q   <= 1'b0;
      out_full_q  <= 1'b0;
      ovf_q       <= 1'b0;
      irq_flag_q  <= 1'b0;
      irq_en_q    <= 1'b0;
      prdata_q    <= 32'h0;
      rd_drive_q  <= 1'b0;
    end else begin
      ext_q       <= ext_d;
      out_latch_q <= out_latch_d;
      in_latch_q  <= in_latch_d;
      wr_data_q   <= wr_data_d;
      mode_q      <= mode_d;
      pin_dir_q   <= pin_dir_d;
      dir_q       <= dir_d;
      in_full_q   <= in_full_d;
      out_full_q  <= out_full_d;
      ovf_q       <= ovf_d;
      irq_flag_q  <= irq_flag_d;
      irq_en_q    <= irq_en_d;
      prdata_q    <= prdata_d;
      rd_drive_q  <= rd_drive_d;
    end
  end

  // outputs; read data and pin data come straight from flops
  always_comb begin
    PRDATA    = prdata_q;
    // error answer is a handshake output, given in the access phase
    PSLVERR   = apb_acc & ~addr_ok;
    DATA_OUT  = out_latch_q;
    // in slave mode direction register is ignored; the pins turn around
    // only as a whole byte, never bit by bit
    DATA_OE_N = mode_q ? {8{~rd_drive_q}} : dir_q;
    DATA_PORT_DIRECTION = dir_q;
    // level interrupt, gated by the enable bit
    IRQ       = irq_flag_q & irq_en_q;
  end

endmodule

// File: bench/psp_asserts.sv
// checker for the slave port: apb answers, data pin drive, irq gating
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ps
module psp_asserts
  import psp_pkg::*;
(
  // clock, reset, apb
  input wire logic        CORE_CLK,
  input wire logic        SYS_RST,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  // pins and interrupt
  input wire logic [7:0]  DATA_OUT,
  input wire logic [7:0]  DATA_OE_N,
  input wire logic        READ_STROBE_N_PIN,
  input wire logic        CHIP_SELECT_N_PIN,
  input wire logic        IRQ
);
  logic       acc;    // access phase
  logic       hit;    // address decodes
  logic       mode_q; // snooped mode bit
  logic       mode_d;
  logic [7:0] pw_q;   // last data byte written
  logic [7:0] pw_d;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  assign acc = PSEL && PENABLE;
  assign hit = PADDR inside {ADDR_DATA, ADDR_STROBE, ADDR_FLAGS, ADDR_CTRL, ADDR_ENABLES};
  // mirror mode and data byte; mode only matters for pin drive
  always_comb begin
    mode_d = mode_q;
    pw_d = pw_q;
    if (acc && PWRITE && PADDR == ADDR_CTRL) mode_d = PWDATA[BIT_MODE];
    if (acc && PWRITE && PADDR == ADDR_DATA) pw_d = PWDATA[7:0];
  end
  always_ff @(posedge CORE_CLK) begin
    mode_q <= SYS_RST ? 1'b0 : mode_d;
    pw_q <= pw_d;
  end
  property p_ready; acc |-> PREADY; endproperty
  property p_err; acc |-> PSLVERR == !hit; endproperty
  property p_rd0; acc && !PWRITE && !hit |-> PRDATA == 32'h0; endproperty
  property p_dout; acc && PWRITE && PADDR == ADDR_DATA |=> ##[0:1] DATA_OUT == pw_q; endproperty
  property p_drv; (mode_q && !READ_STROBE_N_PIN && !CHIP_SELECT_N_PIN)[*5]
    |-> DATA_OE_N == 8'h00; endproperty
  property p_idle; (mode_q && CHIP_SELECT_N_PIN)[*5] |-> DATA_OE_N == 8'hFF; endproperty
  property p_whole; mode_q[*5] |-> DATA_OE_N inside {8'h00, 8'hFF}; endproperty
  property p_mask; acc && PWRITE && PADDR == ADDR_ENABLES && !PWDATA[BIT_IRQ]
    |=> ##[0:1] !IRQ; endproperty
  a_ready: assert property (p_ready) else $error("no ready in access");
  a_err: assert property (p_err) else $error("slverr wrong");
  a_rd0: assert property (p_rd0) else $error("unmapped read nonzero");
  a_dout: assert property (p_dout) else $error("output latch wrong");
  a_drv: assert property (p_drv) else $error("no drive on read");
  a_idle: assert property (p_idle) else $error("drive while deselected");
  a_whole: assert property (p_whole) else $error("partial drive");
  a_mask: assert property (p_mask) else $error("irq not masked");
  c_rd: cover property ((mode_q && !READ_STROBE_N_PIN && !CHIP_SELECT_N_PIN)[*5]);
  c_irq: cover property ($rose(IRQ));
  c_err: cover property (acc && PSLVERR);
endmodule
bind parallel_slave_port psp_asserts chk (.CORE_CLK, .SYS_RST, .PSEL, .PENABLE,
  .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .DATA_OUT, .DATA_OE_N,
  .READ_STROBE_N_PIN, .CHIP_SELECT_N_PIN, .IRQ);

// File: bench/ext_cpu_model.sv
// external processor model: strobes and data pins of the slave port
// assumes no pull-ups, so a floating bus shows the inverse of the last byte
`timescale 1ns/1ps
module ext_cpu_model (
  // clock that paces the strobe cycles
  input  wire logic       clk,
  // strobes, active low
  output logic            rd_n,
  output logic            wr_n,
  output logic            cs_n,
  // data pins
  output logic      [7:0] bus,
  input  wire logic [7:0] dout,
  input  wire logic [7:0] oe_n
);
  logic [7:0] drv_q = 8'h00; // last byte put on the pins
  logic       drv_en = 1'b0; // we drive the pins
  initial begin
    rd_n = 1'b1;
    wr_n = 1'b1;
    cs_n = 1'b1;
  end
  // device wins while enabled, else us, else floating inverse
  assign bus = (oe_n === 8'h00) ? dout : (drv_en ? drv_q : ~drv_q);
  // one strobe cycle, entered right after a rising edge; strobes stay low
  // six clocks and high six more, above the three-clock minimum
  task automatic xfer(input logic rd, input logic sel, input logic [7:0] v,
                      output logic [7:0] got);
    drv_q <= v;
    drv_en <= !rd;
    cs_n <= !sel;
    rd_n <= !rd;
    wr_n <= rd;
    repeat (6) @(posedge clk);
    got = bus;
    rd_n <= 1'b1;
    wr_n <= 1'b1;
    cs_n <= 1'b1;
    // write data held past the release, until the capture is done
    repeat (4) @(posedge clk);
    drv_en <= 1'b0; // hold over: pins float
    repeat (2) @(posedge clk);
  endtask
endmodule

// File: bench/tb_top.sv
// bench for the slave port: apb register tasks plus external strobe cycles
// assumes a zero-wait apb slave and the external processor model
`timescale 1ns/1ps
module tb_top
  import psp_pkg::*;
;
  logic        clk = 0;
  logic        rst = 1;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic        pready, pslverr, irq, rd_n, wr_n, cs_n;
  logic [7:0]  dout, oe_n, bus, got, dir;
  int          num_errors = 0;
  int          comparisons = 0;
  always #25 clk = ~clk;
  parallel_slave_port DUT (.CORE_CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .DATA_IN(bus), .DATA_OUT(dout), .DATA_OE_N(oe_n),
    .READ_STROBE_N_PIN(rd_n), .WRITE_STROBE_N_PIN(wr_n), .CHIP_SELECT_N_PIN(cs_n),
    .DATA_PORT_DIRECTION(dir), .IRQ(irq));
  ext_cpu_model ext (.clk(clk), .rd_n(rd_n), .wr_n(wr_n), .cs_n(cs_n), .bus(bus),
    .dout(dout), .oe_n(oe_n));
  task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e);
    chk_reg({31'h0, g}, {31'h0, e});
  endtask
  // one apb transfer, entered right after a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) num_errors++;
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    chk_reg(r, e);
  endtask
  // external cycle, then realign to the clock
  task automatic ext_op(input logic r, input logic s, input logic [7:0] v);
    ext.xfer(r, s, v, got);
    @(posedge clk);
  endtask
  task automatic close_out;
    if (num_errors == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    num_errors++;
    close_out;
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(ADDR_CTRL, 32'h07);
    rd(ADDR_ENABLES, 32'h00);
    rd(12'h100, 32'h00);
    rd(ADDR_STROBE, 32'h00);
    wr(12'h104, 32'hFF);
    wr(ADDR_CTRL, 32'h17);
    wr(ADDR_STROBE, 32'h00);
    chk_reg({24'h0, dir}, 32'h00);
    wr(ADDR_ENABLES, 32'h80);
    wr(ADDR_DATA, 32'h5A);
    rd(ADDR_CTRL, 32'h57);
    ext_op(1'b1, 1'b1, 8'h00);
    chk_reg({24'h0, got}, 32'h5A);
    rd(ADDR_CTRL, 32'h17);
    chk_bit(irq, 1'b1);
    wr(ADDR_FLAGS, 32'h80);
    chk_bit(irq, 1'b0);
    ext_op(1'b0, 1'b1, 8'hA5);
    rd(ADDR_CTRL, 32'h97);
    ext_op(1'b0, 1'b1, 8'h3C);
    rd(ADDR_CTRL, 32'hB7);
    rd(ADDR_DATA, 32'hA5);
    rd(ADDR_CTRL, 32'h37);
    wr(ADDR_FLAGS, 32'h80);
    ext_op(1'b0, 1'b0, 8'h77);
    rd(ADDR_FLAGS, 32'h00);
    rd(ADDR_CTRL, 32'h37);
    wr(ADDR_ENABLES, 32'h00);
    ext_op(1'b0, 1'b1, 8'hC3);
    chk_bit(irq, 1'b0);
    rd(ADDR_FLAGS, 32'h80);
    wr(ADDR_FLAGS, 32'h80);
    rd(ADDR_DATA, 32'hC3);
    wr(ADDR_DATA, 32'h11);
    wr(ADDR_CTRL, 32'h27);
    rd(ADDR_CTRL, 32'h27);
    wr(ADDR_CTRL, 32'h07);
    rd(ADDR_CTRL, 32'h07);
    ext_op(1'b0, 1'b1, 8'h99);
    rd(ADDR_CTRL, 32'h07);
    rd(ADDR_FLAGS, 32'h00);
    rd(ADDR_DATA, 32'h11);
    close_out;
  end
endmodule
